/* File: rtl/dft_correlator.sv */
// master clock dividers, tone synthesizer and single-point dft correlator
// assumes adc samples arrive synchronous to clock and are valid on each adc tick
`timescale 1ns/100ps
`include "dft_clock_map.svh"
// Operation
// - correlate only at current excitation frequency
// - each result from exactly 1024 samples
// - adc sample tick is clock divided four
// - synthesizer tick is clock divided sixteen
// - 27-bit accumulator, top three bits zero
// - store real and imaginary results after each 1024-sample block
module dft_correlator (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [`PHASE_W-`PHASE_ZERO_MSBS-1:0] freq_increment,
  input wire logic signed [`SAMPLE_W-1:0] adc_sample,
  output logic adc_tick,
  output logic tone_tick,
  output logic signed [7:0] tone_out,
  output logic busy,
  output logic result_valid,
  output dft_types_pkg::dft_result_type result,
  output logic [7:0] real_addr,
  output logic [7:0] imag_addr
);
  import dft_types_pkg::*;

  localparam int PW = `PHASE_W;
  localparam int LW = `PHASE_W - `PHASE_ZERO_MSBS;
  localparam int CW = $clog2(`SAMPLE_COUNT);

  logic [3:0] div_q, div_d;
  logic [PW-1:0] phase_q, phase_d;
  logic signed [7:0] tone_q, tone_d;
  corr_state_type state_q, state_d;
  logic [CW:0] taken_q, taken_d;
  logic [CW:0] used_q, used_d;
  logic signed [`ACC_W-1:0] acc_re_q, acc_re_d, acc_im_q, acc_im_d;
  dft_result_type result_q, result_d;
  logic valid_q, valid_d;
  sample_word_type in_word, out_word;
  logic fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop;
  logic signed [7:0] cos_ref, sin_ref;
  logic [`LUT_ADDR_W-1:0] lut_addr;
  logic [3:0] gap_q, gap_d;

  // single free-running divider gives both slower rates as pulses
  always_comb begin
    div_d = 4'(div_q + 1'b1);
  end
  assign adc_tick = div_q[1:0] == 2'h3;
  assign tone_tick = div_q == 4'hf;

  // phase accumulator: top three bits never leave zero
  always_comb begin
    phase_d = phase_q;
    if (tone_tick) begin
      phase_d = {{`PHASE_ZERO_MSBS{1'b0}}, LW'(phase_q[LW-1:0] + freq_increment)};
    end
  end

  // coarse 16-entry quarter-symmetric sine table addressed by phase top bits
  function automatic logic signed [7:0] sine_lut(input logic [`LUT_ADDR_W-1:0] a);
    logic signed [7:0] mag;
    logic [1:0] q;
    mag = 8'sh00;
    // falling half of each lobe mirrors the rising half about the peak
    if (a[2]) begin
      q = 2'(~a[1:0] + 1'b1);
    end else begin
      q = a[1:0];
    end
    unique case (q)
      2'h0: mag = 8'sh00;
      2'h1: mag = 8'sh31;
      2'h2: mag = 8'sh5a;
      2'h3: mag = 8'sh76;
    endcase
    if (a[2] && a[1:0] == 2'h0) begin
      mag = 8'sh7f;
    end
    return a[3] ? -mag : mag;
  endfunction

  assign lut_addr = phase_q[LW-1 -: `LUT_ADDR_W];
  assign sin_ref = sine_lut(lut_addr);
  assign cos_ref = sine_lut(`LUT_ADDR_W'(lut_addr + 4'h4));
  always_comb begin
    tone_d = tone_tick ? sin_ref : tone_q;
  end

  // each sample is tagged with the reference of the live excitation phase
  assign in_word.sample = adc_sample;
  assign in_word.cos_ref = cos_ref;
  assign in_word.sin_ref = sin_ref;
  assign fifo_push = adc_tick && state_q == run_st && taken_q != (CW+1)'(`SAMPLE_COUNT);
  assign fifo_pop = fifo_out_valid && state_q == run_st;

  // fifo decouples sample capture from the accumulator pipe
  sample_fifo #(
    .WIDTH($bits(sample_word_type)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(in_word),
    .out_valid(fifo_out_valid),
    .out_ready(state_q == run_st),
    .out_data(out_word)
  );

  // sequencer: gathers the block, accumulates, then latches the pair
  always_comb begin
    state_d = state_q;
    taken_d = taken_q;
    used_d = used_q;
    acc_re_d = acc_re_q;
    acc_im_d = acc_im_q;
    result_d = result_q;
    valid_d = 1'b0;
    unique case (state_q)
      idle_st: begin
        if (start) begin
          state_d = run_st;
          taken_d = '0;
          used_d = '0;
          acc_re_d = '0;
          acc_im_d = '0;
        end
      end
      run_st: begin
        if (fifo_push && fifo_in_ready) begin
          taken_d = (CW+1)'(taken_q + 1'b1);
        end
        if (fifo_pop) begin
          acc_re_d = `ACC_W'(acc_re_q + out_word.sample * out_word.cos_ref);
          acc_im_d = `ACC_W'(acc_im_q - out_word.sample * out_word.sin_ref);
          used_d = (CW+1)'(used_q + 1'b1);
          if (used_q == (CW+1)'(`SAMPLE_COUNT - 1)) begin
            state_d = done_st;
          end
        end
      end
      done_st: begin
        result_d.real_part = acc_re_q[`ACC_W-1 -: 16];
        result_d.imag_part = acc_im_q[`ACC_W-1 -: 16];
        valid_d = 1'b1;
        state_d = idle_st;
      end
      default: begin
        state_d = idle_st;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      phase_q <= '0;
      tone_q <= '0;
      state_q <= idle_st;
      taken_q <= '0;
      used_q <= '0;
      acc_re_q <= '0;
      acc_im_q <= '0;
      result_q <= {`RESULT_RESET, `RESULT_RESET};
      valid_q <= 1'b0;
    end else begin
      div_q <= div_d;
      phase_q <= phase_d;
      tone_q <= tone_d;
      state_q <= state_d;
      taken_q <= taken_d;
      used_q <= used_d;
      acc_re_q <= acc_re_d;
      acc_im_q <= acc_im_d;
      result_q <= result_d;
      valid_q <= valid_d;
    end
  end

  assign tone_out = tone_q;
  assign busy = state_q != idle_st;
  assign result_valid = valid_q;
  assign result = result_q;
  assign real_addr = `REAL_RESULT_ADDR;
  assign imag_addr = `IMAG_RESULT_ADDR;

  // assertion helper: cycles since the last synthesizer tick, cleared by it
  always_comb begin
    gap_d = tone_tick ? 4'h0 : 4'(gap_q + 1'b1);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end

  // checks
  a_adc_tick_rate: assert property (@(posedge clock) disable iff (rst)
    adc_tick |=> !adc_tick ##1 !adc_tick ##1 !adc_tick ##1 adc_tick)
    else $error("adc tick not every four cycles");
  // a counter rather than a long repetition keeps the check cheap to unroll
  a_tone_tick_rate: assert property (@(posedge clock) disable iff (rst)
    tone_tick == (gap_q == 4'hf))
    else $error("tone tick not every sixteen cycles");
  a_tone_with_adc: assert property (@(posedge clock) disable iff (rst)
    tone_tick |-> adc_tick)
    else $error("tone tick off the adc grid");
  a_phase_top_zero: assert property (@(posedge clock) disable iff (rst)
    phase_q[PW-1 -: `PHASE_ZERO_MSBS] == '0)
    else $error("phase top bits not zero");
  a_phase_step: assert property (@(posedge clock) disable iff (rst)
    tone_tick |=> phase_q[LW-1:0] == LW'($past(phase_q[LW-1:0]) + $past(freq_increment)))
    else $error("phase did not step by increment");
  a_block_length: assert property (@(posedge clock) disable iff (rst)
    state_q == run_st && state_d == done_st |-> taken_q == (CW+1)'(`SAMPLE_COUNT))
    else $error("block not 1024 samples");
  // a lost sample would leave a gap in the consecutive block
  a_fifo_no_overflow: assert property (@(posedge clock) disable iff (rst)
    fifo_push |-> fifo_in_ready)
    else $error("sample lost at full fifo");
  a_result_update: assert property (@(posedge clock) disable iff (rst)
    state_q == done_st |=> result_valid && result.real_part == $past(acc_re_q[`ACC_W-1 -: 16]))
    else $error("real result not stored");
  a_imag_update: assert property (@(posedge clock) disable iff (rst)
    state_q == done_st |=> result.imag_part == $past(acc_im_q[`ACC_W-1 -: 16]))
    else $error("imaginary result not stored");
  a_result_pulse: assert property (@(posedge clock) disable iff (rst)
    result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  // a reference pushed on a tone tick is the sample the output then carries
  a_ref_tracks_tone: assert property (@(posedge clock) disable iff (rst)
    fifo_push && tone_tick |=> tone_out == $past(in_word.sin_ref))
    else $error("reference not at excitation phase");
endmodule

/* File: rtl/dft_clock_map.svh */
// constants for the clock dividers, tone synthesizer and single-point correlator
// assumed to be included by the type package and the top module
`ifndef DFT_CLOCK_MAP_SVH
`define DFT_CLOCK_MAP_SVH
`define ADC_DIV 4
`define TONE_DIV 16
`define PHASE_W 27
`define PHASE_ZERO_MSBS 3
`define SAMPLE_COUNT 1024
`define SAMPLE_W 12
`define ACC_W 32
`define LUT_ADDR_W 4
`define FIFO_DEPTH 4
`define REAL_RESULT_ADDR 8'h94
`define IMAG_RESULT_ADDR 8'h96
`define RESULT_RESET 16'h0000
`endif

/* File: rtl/dft_types_pkg.sv */
// types shared by the correlator top and the testbench
// assumes dft_clock_map.svh sits on the include path
`include "dft_clock_map.svh"
package dft_types_pkg;
  typedef struct packed {
    logic signed [`SAMPLE_W-1:0] sample;
    logic signed [7:0] cos_ref;
    logic signed [7:0] sin_ref;
  } sample_word_type;
  typedef struct packed {
    logic signed [15:0] real_part;
    logic signed [15:0] imag_part;
  } dft_result_type;
  typedef enum logic [1:0] {idle_st, run_st, done_st} corr_state_type;
endpackage

/* File: rtl/sample_fifo.sv */
// small flip-flop fifo carrying tagged adc samples to the accumulator
// assumes one clock, synchronous valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // full and empty come straight from the fill count
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update, one entry written per push
  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  // storage entries, one per slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_comb begin
      mem_d[i] = (push && wr_q == AW'(i)) ? in_data : mem_q[i];
    end
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: sim/response_source.sv */
// behavioural response path: echoes the excitation back as adc samples
// assumes the bench makes the master clock and drives nothing on adc_sample
`timescale 1ns/100ps
module response_source (
  input wire logic clock,
  input wire logic enable,
  input wire logic signed [7:0] tone_out,
  output logic signed [11:0] adc_sample
);
  // master clock is taken already scaled and selected, no divider here
  // new sample off the sampling edge; zero when the path is muted
  always @(negedge clock) begin
    adc_sample <= enable ? {tone_out, 4'h0} : 12'h000;
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the divider, tone synthesizer and correlator
// assumes the response model stands at the adc input
`timescale 1ns/100ps
module testbench;
  import dft_types_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic echo = 1'b0;
  logic [23:0] freq_increment = 24'h000000;
  logic signed [11:0] adc_sample;
  logic adc_tick, tone_tick, busy, result_valid;
  logic signed [7:0] tone_out;
  dft_result_type result;
  logic [7:0] real_addr, imag_addr;
  int n_mismatch = 0;
  int checks = 0;
  dft_correlator i_dut (.clock(clock), .rst(rst), .start(start),
    .freq_increment(freq_increment), .adc_sample(adc_sample), .adc_tick(adc_tick),
    .tone_tick(tone_tick), .tone_out(tone_out), .busy(busy),
    .result_valid(result_valid), .result(result), .real_addr(real_addr),
    .imag_addr(imag_addr));
  response_source i_src (.clock(clock), .enable(echo), .tone_out(tone_out),
    .adc_sample(adc_sample));
  always #2 clock = ~clock;
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // idle outputs straight after reset
  task automatic test_reset();
    chk(result === 32'h00000000 && result_valid === 1'b0, "result after reset");
    chk(busy === 1'b0, "busy after reset");
    chk(real_addr === 8'h94 && imag_addr === 8'h96, "result addresses");
    $display("test_reset done");
  endtask
  // tick spacing over a few synthesizer periods
  task automatic test_ticks();
    int last_a, last_t, bad_a, bad_t, bad_c;
    last_a = -1;
    last_t = -1;
    bad_a = 0;
    bad_t = 0;
    bad_c = 0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      if (adc_tick === 1'b1) begin
        if (last_a >= 0 && i - last_a != 4) bad_a++;
        last_a = i;
      end
      if (tone_tick === 1'b1) begin
        if (last_t >= 0 && i - last_t != 16) bad_t++;
        if (adc_tick !== 1'b1) bad_c++;
        last_t = i;
      end
    end
    chk(bad_a == 0 && last_a >= 0, "adc tick spacing");
    chk(bad_t == 0 && last_t >= 0, "tone tick spacing");
    chk(bad_c == 0, "tone tick off an adc tick");
    $display("test_ticks done");
  endtask
  // one block: samples counted, late start refused, result pulse judged
  task automatic run_block(output logic [31:0] res, output int changes);
    int ticks, cyc, width;
    logic signed [7:0] prev;
    ticks = 0;
    cyc = 0;
    width = 0;
    changes = 0;
    prev = tone_out;
    @(negedge clock) start = 1'b1;
    // the loop lowers start at this edge, and again after the late pulse at cyc 2000
    @(negedge clock);
    while (result_valid !== 1'b1 && cyc < 5000) begin
      if (busy === 1'b1 && adc_tick === 1'b1) ticks++;
      if (tone_out !== prev) changes++;
      prev = tone_out;
      start = (cyc == 2000);
      @(negedge clock);
      cyc++;
    end
    res = result;
    while (result_valid === 1'b1 && width < 4) begin
      width++;
      @(negedge clock);
    end
    chk(ticks >= 1024 && ticks <= 1026, "samples in block");
    chk(cyc >= 4093 && cyc <= 4106, "block length with late start");
    chk(width == 1, "result_valid width");
  endtask
  task automatic test_blocks();
    logic [31:0] r;
    int ch;
    run_block(r, ch);
    chk(r === 32'h00000000, "silent input gives zero");
    chk(ch == 0, "tone still with zero increment");
    echo = 1'b1;
    freq_increment = 24'h100000;
    run_block(r, ch);
    chk(ch > 100, "tone moves with increment");
    chk(r !== 32'h00000000, "echoed tone correlates");
    freq_increment = 24'hffffff;
    run_block(r, ch);
    chk(ch > 0, "largest increment still steps");
    $display("test_blocks done");
  endtask
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    test_reset();
    test_ticks();
    test_blocks();
    end_of_test();
  end
  // three blocks plus margin; a hang counts as a mismatch
  initial begin
    #80000;
    n_mismatch++;
    end_of_test();
  end
endmodule
